// ===== rtl/mdi_pkg.sv
package mdi_pkg;
  // bus address and frame layout
  localparam logic [6:0] MDI_TARGET_ADDR = 7'h66;
  localparam int         MDI_NUM_REGS    = 6;
  // register indices
  localparam logic [7:0] MDI_REG_CONFIG  = 8'h00;
  localparam logic [7:0] MDI_REG_OSC     = 8'h01;
  localparam logic [7:0] MDI_REG_HAP_A   = 8'h02;
  localparam logic [7:0] MDI_REG_HAP_B   = 8'h03;
  localparam logic [7:0] MDI_REG_HAPTIC_REGULATOR_VOLTAGE  = 8'h04;
  localparam logic [7:0] MDI_REG_VIBRATE_REGULATOR_VOLTAGE = 8'h05;
  // reset values
  localparam logic [7:0] MDI_RST_CONFIG  = 8'h01;
  localparam logic [7:0] MDI_RST_OSC     = 8'h00;
  localparam logic [7:0] MDI_RST_HAP_A   = 8'h0a;
  localparam logic [7:0] MDI_RST_HAP_B   = 8'h85;
  localparam logic [7:0] MDI_RST_HAPTIC_REGULATOR_VOLTAGE  = 8'h00;
  localparam logic [7:0] MDI_RST_VIBRATE_REGULATOR_VOLTAGE = 8'h1a;
  // config fields
  localparam int MDI_CFG_CHIP_EN = 0;
  localparam int MDI_CFG_HTRIG   = 1;
  localparam int MDI_CFG_VIBEN   = 2;
  // regulator code: 0 means follow input supply, else 51 - code (x0.1 V)
  localparam logic [4:0] MDI_CODE_BYPASS = 5'h00;
  localparam logic [5:0] MDI_DV_TOP      = 6'h33;
  // timing at 20 MHz
  localparam int MDI_CLK_HZ     = 20_000_000;
  localparam int MDI_BUS_HZ     = 400_000;
  localparam int MDI_HALF_CYC   = MDI_CLK_HZ / MDI_BUS_HZ / 2;
  localparam int MDI_RESP_NS    = 40_000;
  localparam int MDI_RESP_CYC   = MDI_RESP_NS / 50;
  // host command port registers
  localparam logic [1:0] MDI_HOST_CTRL   = 2'h0;
  localparam logic [1:0] MDI_HOST_STATUS = 2'h1;
  localparam logic [1:0] MDI_HOST_RDATA  = 2'h2;
endpackage

// ===== rtl/mdi_bus_if.sv
interface mdi_bus_if;
  logic scl_o;
  logic scl_oe;
  logic sda_host_o;
  logic sda_host_oe;
  logic sda_dev_o;
  logic sda_dev_oe;
  logic scl;
  logic sda;
  // open drain wire, pulled up
  assign scl = ~(scl_oe & ~scl_o);
  assign sda = ~((sda_host_oe & ~sda_host_o) | (sda_dev_oe & ~sda_dev_o));
  modport host (output scl_o, scl_oe, sda_host_o, sda_host_oe,
                input scl, sda);
  modport device (output sda_dev_o, sda_dev_oe, input scl, sda);
endinterface

// ===== rtl/mdi_device.sv
// Notes on behaviour
// R01: answer only address 1100110, fixed
// R02: read: pointer write, repeated start, one byte
// R03: ack address, pointer and data bytes
// R04: host naks the read byte, then stops
// R05: six 8-bit registers, 8-bit pointer
// R06: bus up to 400 kbit/s
// R07: host starts every transfer; idle high
// R08: code 0 bypass, else 5.0 to 2.0 V
// R09: output is min of code and supply
// R10: vibrate forward only; trigger edge both directions (the code drives a trigger edge in reverse only)
// R11: bridge responds 40 us after activation
// R12: write: address, pointer, one data byte
//
// Local design decisions: the register addresses and the address-and-strobe port.
module mdi_device
  import mdi_pkg::*;
(
  // clock and reset
  input  wire logic       clock,
  input  wire logic       rst_n,
  // bus
  mdi_bus_if.device       bus,
  // user side
  input  wire logic       haptic_trigger,
  input  wire logic       vibrate_enable,
  input  wire logic [5:0] input_supply,
  output logic [7:0]      regs_flat [MDI_NUM_REGS],
  output logic            drive_forward,
  output logic            drive_reverse,
  output logic [5:0]      regulator_dv
);
  typedef enum logic [2:0] {
    MDI_IDLE  = 3'b000,
    MDI_ADDR  = 3'b001,
    MDI_PTR   = 3'b010,
    MDI_WDATA = 3'b011,
    MDI_RDATA = 3'b100,
    MDI_RACK  = 3'b101,
    MDI_SKIP  = 3'b110
  } mdi_state_e;

  typedef struct packed {
    mdi_state_e  st;
    logic        scl_q;
    logic        sda_q;
    logic [3:0]  bitn;
    logic [7:0]  sh;
    logic        ack;
    logic        drive;
    logic        dbit;
    logic [7:0]  ptr;
    logic [5:0][7:0] regs;
    logic        trig_q;
    logic        seq_fwd;
    logic        seq_rev;
    logic [9:0]  dly;
    logic        run;
    logic [5:0]  dv;
  } mdi_dev_s;

  mdi_dev_s r, n;
  logic scl_rise, scl_fall, start_c, stop_c, vib, trig;
  logic [5:0] sel_dv;
  logic [4:0] code;

  assign scl_rise = bus.scl & ~r.scl_q;
  assign scl_fall = ~bus.scl & r.scl_q;
  assign start_c  = bus.scl & r.scl_q & r.sda_q & ~bus.sda; // R07
  assign stop_c   = bus.scl & r.scl_q & ~r.sda_q & bus.sda;

  ////////////////////////////////////////////////////////////////////
  always_comb begin
    n = r;
    n.scl_q = bus.scl;
    n.sda_q = bus.sda;
    if (start_c) begin
      // repeated start keeps the pointer for the read phase
      n.st = MDI_ADDR; // R02
      n.bitn = 4'h0;
      n.ack = 1'b0;
      n.drive = 1'b0;
    end else if (stop_c) begin
      n.st = MDI_IDLE;
      n.drive = 1'b0;
    end else if (r.st != MDI_IDLE && (r.st != MDI_SKIP || r.ack)) begin
      // skip still has to let go of the data-byte ack
      if (scl_rise && !r.ack) begin
        if (r.st == MDI_RACK) begin
          // host nak ends reading; ack would just re-send same byte
          n.st = bus.sda ? MDI_SKIP : MDI_RDATA; // R04
        end else if (r.st != MDI_RDATA) begin
          n.sh = {r.sh[6:0], bus.sda};
        end
        n.bitn = r.bitn + 4'h1;
      end
      if (scl_fall) begin
        if (r.ack) begin
          n.ack = 1'b0;
          n.bitn = 4'h0;
          n.drive = 1'b0;
          if (r.st == MDI_RDATA) begin
            // first read bit goes out as the address ack ends
            n.drive = 1'b1;
            n.dbit = (r.ptr < 8'(MDI_NUM_REGS)) ?
                     r.regs[r.ptr[2:0]][7] : 1'b1;
          end
        end else if (r.bitn == 4'h8) begin
          n.ack = 1'b1;
          n.drive = 1'b1;
          n.dbit = 1'b0;
          case (r.st)
            MDI_ADDR: begin
              if (r.sh[7:1] != MDI_TARGET_ADDR) begin // R01
                n.st = MDI_SKIP;
                n.ack = 1'b0;
                n.drive = 1'b0;
              end else if (r.sh[0]) begin
                n.st = MDI_RDATA; // R02
              end else begin
                n.st = MDI_PTR; // R03
              end
            end
            MDI_PTR: begin
              n.ptr = r.sh; // R05
              n.st = MDI_WDATA;
            end
            MDI_WDATA: begin
              if (r.ptr < 8'(MDI_NUM_REGS)) begin
                n.regs[r.ptr[2:0]] = r.sh; // R12
              end
              n.st = MDI_SKIP; // R12
            end
            MDI_RDATA: begin
              n.ack = 1'b0;
              n.drive = 1'b0;
              n.st = MDI_RACK;
            end
            default: n.st = MDI_SKIP;
          endcase
        end
        if (r.st == MDI_RDATA && !r.ack && r.bitn < 4'h8) begin
          n.drive = 1'b1;
          n.dbit = (r.ptr < 8'(MDI_NUM_REGS)) ?
                   r.regs[r.ptr[2:0]][3'(7 - r.bitn)] : 1'b1;
        end
      end
    end
    // motor side
    vib  = r.regs[0][MDI_CFG_CHIP_EN] &
           (vibrate_enable | r.regs[0][MDI_CFG_VIBEN]);
    trig = r.regs[0][MDI_CFG_CHIP_EN] &
           (haptic_trigger | r.regs[0][MDI_CFG_HTRIG]);
    n.trig_q = trig;
    if ((trig & ~r.trig_q) | (vib & ~r.run)) begin
      n.dly = 10'(MDI_RESP_CYC); // R11
      n.run = 1'b1;
      n.seq_rev = ~vib & trig;
    end else if (r.dly != 10'h0) begin
      n.dly = r.dly - 10'h1;
    end
    if (!vib && !trig && r.dly == 10'h0) begin
      n.run = 1'b0;
    end
    // forward for vibrate, reverse for haptic kick
    n.seq_fwd = r.run && r.dly == 10'h0 && (vib || !r.seq_rev); // R10
    code = vib ? r.regs[5][4:0] : r.regs[4][4:0];
    sel_dv = (code == MDI_CODE_BYPASS) ? input_supply
             : MDI_DV_TOP - {1'b0, code}; // R08
    n.dv = (sel_dv < input_supply) ? sel_dv : input_supply; // R09
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      r <= '{st: MDI_IDLE, scl_q: 1'b1, sda_q: 1'b1, bitn: 4'h0,
             sh: 8'h00, ack: 1'b0, drive: 1'b0, dbit: 1'b1, ptr: 8'h00,
             regs: {MDI_RST_VIBRATE_REGULATOR_VOLTAGE,
                    MDI_RST_HAPTIC_REGULATOR_VOLTAGE, MDI_RST_HAP_B,
                    MDI_RST_HAP_A, MDI_RST_OSC, MDI_RST_CONFIG},
             trig_q: 1'b0, seq_fwd: 1'b0, seq_rev: 1'b0, dly: 10'h000,
             run: 1'b0, dv: 6'h00};
    end else begin
      r <= n;
    end
  end

  ////////////////////////////////////////////////////////////////////
  genvar gi;
  generate
    for (gi = 0; gi < MDI_NUM_REGS; gi++) begin : g_regs
      assign regs_flat[gi] = r.regs[gi];
    end
  endgenerate
  assign bus.sda_dev_o  = r.dbit;
  assign bus.sda_dev_oe = r.drive;
  assign drive_forward  = r.seq_fwd;
  assign drive_reverse  = r.run & (r.dly == 10'h0) & ~r.seq_fwd;
  assign regulator_dv   = r.dv;
endmodule

// ===== rtl/mdi_host.sv
module mdi_host
  import mdi_pkg::*;
(
  // clock and reset
  input  wire logic       clock,
  input  wire logic       rst_n,
  // command port
  input  wire logic [1:0] addr,
  input  wire logic [15:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output logic [15:0]     rdata,
  // bus
  mdi_bus_if.host         bus
);
  typedef enum logic [1:0] {
    MDI_H_IDLE = 2'b00,
    MDI_H_RUN  = 2'b01
  } mdi_hst_e;

  // 2 phases of half bit each per bit, script built at launch
  typedef struct packed {
    mdi_hst_e   st;
    logic [5:0] cnt;
    logic [6:0] step;
    logic       scl;
    logic       sda;
    logic       is_rd;
    logic [7:0] ptr;
    logic [7:0] dat;
    logic [7:0] rx;
    logic       nak;
    logic [15:0] rdat;
  } mdi_hst_s;

  mdi_hst_s r, n;
  logic [6:0] last;
  logic [6:0] s;
  logic [5:0] k;
  logic [3:0] bit_i;
  logic [7:0] cur;

  ////////////////////////////////////////////////////////////////////
  always_comb begin
    n = r;
    last = r.is_rd ? 7'd78 : 7'd56;
    // repeated start takes four half bits out of the read script
    s = (r.is_rd && r.step > 7'd40) ? r.step - 7'd4 : r.step;
    k = r.step[0] ? 6'(s / 7'd2) : 6'(s / 7'd2) - 6'h1;
    bit_i = 4'(k % 6'd9);
    cur = 8'h00;
    if (rd) begin
      n.rdat = (addr == MDI_HOST_STATUS) ? {14'h0, r.nak, r.st == MDI_H_RUN}
             : (addr == MDI_HOST_RDATA) ? {8'h00, r.rx} : 16'h0000;
    end
    if (wr && addr == MDI_HOST_CTRL && r.st == MDI_H_IDLE) begin
      // wdata: [15] read, [14:8] pointer, [7:0] data
      n.st = MDI_H_RUN; // R07
      n.is_rd = wdata[15];
      n.ptr = wdata[15:8] & 8'h7f;
      n.dat = wdata[7:0];
      n.ptr = {1'b0, wdata[14:8]};
      n.step = 7'd0;
      n.cnt = 6'h0;
      n.nak = 1'b0;
      n.sda = 1'b0;
    end else if (r.st == MDI_H_RUN) begin
      n.cnt = r.cnt + 6'h1;
      if (r.cnt == 6'(MDI_HALF_CYC - 1)) begin // R06
        n.cnt = 6'h0;
        n.step = r.step + 7'd1;
        // odd steps drop scl and present a bit, even steps raise it
        n.scl = ~r.step[0];
        if (k < 6'd9) cur = {MDI_TARGET_ADDR, 1'b0};
        else if (k < 6'd18) cur = r.ptr;
        else if (!r.is_rd) cur = r.dat;
        else if (k < 6'd27) cur = {MDI_TARGET_ADDR, 1'b1}; // R02
        else cur = 8'hff;
        if (r.step[0]) begin
          // ack slots released, so the read byte gets a nak
          n.sda = (bit_i == 4'h8) ? 1'b1 : cur[3'(4'h7 - bit_i)];
        end else if (bit_i == 4'h8 && bus.sda) begin
          n.nak = (k != 6'd35) | r.nak; // R03
        end else if (r.is_rd && k >= 6'd27 && k < 6'd35) begin
          n.rx = {r.rx[6:0], bus.sda};
        end
        if (r.is_rd && r.step == 7'd37) begin
          n.sda = 1'b1; // repeated start setup
        end
        if (r.is_rd && r.step == 7'd39) begin
          n.scl = 1'b1;
          n.sda = 1'b0; // R02
        end
        if (r.step == last - 7'd1) n.sda = 1'b0;
        if (r.step == last + 7'd1) begin
          n.scl = 1'b1;
          n.sda = 1'b1; // stop
          n.st = MDI_H_IDLE; // R12
        end
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      r <= '{st: MDI_H_IDLE, cnt: 6'h00, step: 7'h00, scl: 1'b1,
             sda: 1'b1, is_rd: 1'b0, ptr: 8'h00, dat: 8'h00,
             rx: 8'h00, nak: 1'b0, rdat: 16'h0000};
    end else begin
      r <= n;
    end
  end

  ////////////////////////////////////////////////////////////////////
  assign rdata           = r.rdat;
  assign bus.scl_o       = r.scl;
  assign bus.scl_oe      = ~r.scl;
  assign bus.sda_host_o  = r.sda;
  assign bus.sda_host_oe = ~r.sda;
endmodule

// ===== testbench/mdi_bus_assertions.sv
module mdi_bus_assertions
  import mdi_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // resolved bus and the device's sda drive enable
  input wire logic scl,
  input wire logic sda,
  input wire logic sda_dev_oe
);
  logic       scl_q;
  logic       sda_q;
  logic       in_frame;
  logic       rs;
  logic [5:0] bitn;
  logic [7:0] hcnt;
  logic [9:0] idle;
  logic       rise;
  logic       start;
  logic       stop;
  assign rise  = scl & ~scl_q;
  assign start = scl & scl_q & sda_q & ~sda;
  assign stop  = scl & scl_q & ~sda_q & sda;
  // bit index restarts at every start, so a repeated start opens a new frame
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      scl_q    <= 1'b1;
      sda_q    <= 1'b1;
      in_frame <= 1'b0;
      rs       <= 1'b0;
      bitn     <= 6'h00;
      hcnt     <= 8'h00;
      idle     <= 10'h000;
    end else begin
      scl_q    <= scl;
      sda_q    <= sda;
      in_frame <= start | (in_frame & ~stop);
      rs       <= (start & in_frame) | (rs & ~stop);
      bitn     <= start ? 6'h00 : bitn + {5'h00, rise};
      hcnt     <= rise ? 8'h00 : hcnt + {7'h00, hcnt != 8'hff};
      idle     <= (scl & sda) ? idle + {9'h000, idle != 10'h3ff} : 10'h000;
    end
  end
  //////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  a_reset_idle_bus: assert property ($rose(rst_n) |-> scl && sda
    && !sda_dev_oe) else $error("bus not idle after reset");
  a_addr_msb_first: assert property (rise && in_frame && bitn < 6'h07
    |-> sda == MDI_TARGET_ADDR[3'h6 - bitn[2:0]]) else $error("addr bit");
  a_rw_bit_order: assert property (rise && in_frame && bitn == 6'h07
    |-> sda == rs) else $error("read write bit");
  a_addr_ack_low: assert property (rise && in_frame && bitn == 6'h08
    |-> !sda) else $error("address not acked");
  a_ptr_ack_low: assert property (rise && in_frame && !rs
    && bitn == 6'h11 |-> !sda) else $error("pointer not acked");
  a_read_nak_high: assert property (rise && in_frame && rs
    && bitn == 6'h11 |-> sda) else $error("read byte not naked");
  a_data_ack_low: assert property (rise && in_frame && !rs
    && bitn == 6'h1a |-> !sda) else $error("data not acked");
  a_bus_rate_max: assert property (rise && in_frame
    && bitn inside {[6'h01:6'h11]} |-> hcnt >= 2 * MDI_HALF_CYC - 2)
    else $error("bus clock too fast");
  a_dev_scl_low: assert property ($changed(sda_dev_oe) |-> !scl)
    else $error("device moved data while clock high");
  a_dev_idle_off: assert property (idle >= 10'h064 |-> !sda_dev_oe)
    else $error("device holds idle bus");
  a_start_hold: assert property (start |=> scl [*8])
    else $error("start hold short");
endmodule

// ===== testbench/motor_driver_i2c_reg_access_tb_top.sv
module motor_driver_i2c_reg_access_tb_top
  import mdi_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clock;
  logic        rst_n;
  logic [1:0]  addr;
  logic [15:0] wdata;
  logic        wr;
  logic        rd;
  logic [15:0] rdata;
  logic        haptic_trigger;
  logic        vibrate_enable;
  logic [5:0]  input_supply;
  logic [7:0]  regs_flat [MDI_NUM_REGS];
  logic        drive_forward;
  logic        drive_reverse;
  logic [5:0]  regulator_dv;
  logic [15:0] st;
  logic [15:0] d;
  int          n_errors;
  int          samples_checked;
  // code, supply, expected volts x10
  logic [23:0] rows [5] = '{24'h00_37_37, 24'h01_37_32, 24'h1f_37_14,
                            24'h1a_16_16, 24'h10_37_23};
  mdi_bus_if bus_if ();
  mdi_host mdi_host_inst (.clock(clock), .rst_n(rst_n), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .bus(bus_if));
  mdi_device mdi_device_inst (.clock(clock), .rst_n(rst_n), .bus(bus_if),
    .haptic_trigger(haptic_trigger), .vibrate_enable(vibrate_enable),
    .input_supply(input_supply), .regs_flat(regs_flat),
    .drive_forward(drive_forward), .drive_reverse(drive_reverse),
    .regulator_dv(regulator_dv));
  mdi_bus_assertions mdi_bus_assertions_inst (.clock(clock), .rst_n(rst_n),
    .scl(bus_if.scl), .sda(bus_if.sda), .sda_dev_oe(bus_if.sda_dev_oe));
  //////////////////////////////////////////////////////////////////////////
  task automatic chk(string nm, logic [15:0] exp, logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic hw(logic [1:0] a, logic [15:0] v);
    @(posedge clock);
    addr  <= a;
    wdata <= v;
    wr    <= 1'b1;
    @(posedge clock);
    wr    <= 1'b0;
  endtask
  task automatic hr(logic [1:0] a, output logic [15:0] v);
    @(posedge clock);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clock);
    rd   <= 1'b0;
    #1;
    v = rdata;
  endtask
  // polling costs two cycles a round; a read needs about 1000 rounds
  task automatic xfer(logic rdn, logic [7:0] ptr, logic [7:0] v);
    hw(MDI_HOST_CTRL, {rdn, ptr[6:0], v});
    for (int i = 0; i < 2000; i++) begin
      hr(MDI_HOST_STATUS, st);
      if (st[0] === 1'b0) break;
    end
    chk("idle_nak", 16'h0000, st & 16'h0003);
  endtask
  task automatic chk_defaults();
    logic [7:0] dflt [MDI_NUM_REGS];
    dflt = '{MDI_RST_CONFIG, MDI_RST_OSC, MDI_RST_HAP_A, MDI_RST_HAP_B,
      MDI_RST_HAPTIC_REGULATOR_VOLTAGE, MDI_RST_VIBRATE_REGULATOR_VOLTAGE};
    for (int i = 0; i < MDI_NUM_REGS; i++) begin
      chk("reset_reg", {8'h00, dflt[i]}, {8'h00, regs_flat[i]});
    end
    $display("reset test done");
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  initial begin
    repeat (100000) @(posedge clock);
    n_errors++;
    end_of_test();
  end
  initial begin
    rst_n = 1'b0;
    addr = 2'h0;
    wdata = 16'h0000;
    wr = 1'b0;
    rd = 1'b0;
    haptic_trigger = 1'b0;
    vibrate_enable = 1'b0;
    input_supply = 6'h37;
    n_errors = 0;
    samples_checked = 0;
    repeat (20) @(posedge clock);
    rst_n <= 1'b1;
    chk_defaults();
    xfer(1'b1, MDI_REG_HAP_B, 8'h00);
    hr(MDI_HOST_RDATA, d);
    chk("read_hap_b", {8'h00, MDI_RST_HAP_B}, d);
    // both codes equal, so either mode's selection gives the same output
    foreach (rows[i]) begin
      input_supply <= rows[i][13:8];
      xfer(1'b0, MDI_REG_HAPTIC_REGULATOR_VOLTAGE, rows[i][23:16]);
      xfer(1'b0, MDI_REG_VIBRATE_REGULATOR_VOLTAGE, rows[i][23:16]);
      xfer(1'b1, MDI_REG_VIBRATE_REGULATOR_VOLTAGE, 8'h00);
      hr(MDI_HOST_RDATA, d);
      chk("readback", {8'h00, rows[i][23:16]}, d);
      chk("dv", {8'h00, rows[i][7:0]}, {10'h000, regulator_dv});
      $display("row %0d done", i);
    end
    xfer(1'b0, 8'h06, 8'h5a);
    chk("dropped", 16'h0010, {8'h00, regs_flat[5]});
    xfer(1'b1, 8'h06, 8'h00);
    hr(MDI_HOST_RDATA, d);
    chk("unmapped", 16'h00ff, d);
    $display("pointer range test done");
    vibrate_enable <= 1'b1;
    repeat (700) @(posedge clock);
    chk("fwd_early", 16'h0000, {15'h0000, drive_forward});
    repeat (200) @(posedge clock);
    chk("fwd", 16'h0001, {15'h0000, drive_forward});
    chk("rev_vib", 16'h0000, {15'h0000, drive_reverse});
    vibrate_enable <= 1'b0;
    repeat (100) @(posedge clock);
    haptic_trigger <= 1'b1;
    repeat (850) @(posedge clock);
    chk("rev_hap", 16'h0001, {15'h0000, drive_reverse});
    haptic_trigger <= 1'b0;
    $display("motor test done");
    rst_n <= 1'b0;
    repeat (20) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    chk_defaults();
    end_of_test();
  end
endmodule
